// ### hw/cascaded_pulse_counter.sv
// cascaded pulse counter for one meter input channel
// assumes contact input is asynchronous and already voltage-free; controller logic runs on clk
`timescale 1ns/1ps
// What this block does
// - four stage values exposed as condition outputs
// - each stage holds zero to 255
// - stage overflow clears it, carries upward
// - stage weights 1, 256, 65536, 16777216
// - last-interval tally kept, default one minute
// - empty interval keeps previous tally, max 255
// - logic reset condition clears all stages
// - reached value pulses output, clears, loses nothing
// - accepts one pulse every 250 ms
// - interval configurable 1 to 255 minutes
// - report also when interval tally hits 255
// - warning while total at or above trigger
module cascaded_pulse_counter import pulse_counter_pkg::*; #(
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC, // shorten for simulation
    parameter longint MINUTE_CYCLES = MINUTE_CYC // shorten for simulation
) (
    input wire logic clk, // 100 MHz clock
    input wire logic nrst, // async reset, active low
    input wire logic pulse_in, // meter contact, asynchronous
    input wire logic clear_req, // logic-driven reset condition
    input wire logic [7:0] interval_min, // interval in minutes, 0 read as 1
    input wire logic [31:0] trigger_value, // warning threshold
    input wire logic [31:0] reset_value, // total that clears counter, 0 disables
    output logic [7:0] low_stage, // units of 1
    output logic [7:0] second_stage, // units of 256
    output logic [7:0] third_byte_stage, // units of 65536
    output logic [7:0] top_byte_stage, // units of 16777216
    output logic [7:0] last_count, // pulses of last interval
    output logic report_pulse, // one-cycle report strobe
    output logic warning_out, // total at or above trigger
    output logic reset_hit // one-cycle: reset value reached
);
    // ==========================================
    // elaboration checks: a zero count would stall the debounce or the interval timer
    if (DEBOUNCE_CYCLES < 1 || MINUTE_CYCLES < 1) begin : g_bad_cycles
        $error("cycle counts must be at least one");
    end

    count_state_s q; // registered state
    count_state_s d; // next state
    logic edge_seen; // accepted rising edge
    logic [31:0] total; // whole count
    logic [31:0] bumped; // total plus one pulse
    logic cleared; // any clear this cycle
    logic interval_end; // last minute of interval done
    logic [7:0] eff_minutes; // interval, 0 mapped to 1

    // ==========================================
    // combined next-state logic
    always_comb begin
        d = q;
        total = q.stage; // stage 0 is bits 7:0, binary weights
        d.sync = {q.sync[0], pulse_in};
        // debounce: level follows sync only after it stays different long enough
        // hold time sits far below half the fastest pulse period, so no closure is dropped
        if (q.sync[1] == q.level) begin
            d.deb_cnt = '0;
        end else if (q.deb_cnt >= 32'(DEBOUNCE_CYCLES - 1)) begin
            d.level = q.sync[1];
            d.deb_cnt = '0;
        end else begin
            d.deb_cnt = q.deb_cnt + 32'd1;
        end
        edge_seen = (q.sync[1] != q.level) && q.sync[1] && (q.deb_cnt >= 32'(DEBOUNCE_CYCLES - 1));
        // ripple carry across bytes, each stage wraps 255 to 0
        bumped = total + 32'd1;
        // reset-value hit: the pulse that reaches it also clears, none lost
        // an explicit clear in the same cycle wins, so no hit strobe then
        d.hit = edge_seen && !clear_req && (reset_value != TOTAL_ZERO) && (bumped >= reset_value);
        cleared = clear_req || d.hit;
        if (clear_req) begin
            // clear wins, coincident pulse becomes the first one
            d.stage = edge_seen ? (TOTAL_ZERO + 32'd1) : TOTAL_ZERO;
        end else if (d.hit) begin
            d.stage = bumped - reset_value; // excess kept
        end else if (edge_seen) begin
            d.stage = bumped;
        end
        // interval timing: minute prescaler, then minute countdown
        // zero minutes is read as the default, so the timer never spins on an empty span
        eff_minutes = (interval_min == STAGE_ZERO) ? MINUTES_DEFAULT : interval_min;
        interval_end = 1'b0;
        d.report = 1'b0;
        if (q.min_cnt >= 48'(MINUTE_CYCLES - 1)) begin
            d.min_cnt = '0;
            if (q.min_left <= MINUTES_DEFAULT) begin
                interval_end = 1'b1;
                d.min_left = eff_minutes;
            end else begin
                d.min_left = q.min_left - 8'd1;
            end
        end else begin
            d.min_cnt = q.min_cnt + 48'd1;
        end
        // running tally saturates at 255
        if (edge_seen && q.tally_run != STAGE_MAX) begin
            d.tally_run = q.tally_run + 8'd1;
        end
        if (interval_end) begin
            d.report = 1'b1; // periodic report
            if (d.tally_run != STAGE_ZERO) begin
                d.tally_last = d.tally_run;
            end // empty interval keeps old tally
            d.tally_run = STAGE_ZERO;
        end else if (edge_seen && q.tally_run == STAGE_MAX - 8'd1) begin
            d.report = 1'b1; // extra report at 255
            d.tally_last = STAGE_MAX;
        end
        d.warning = (d.stage >= trigger_value);
    end

    // ==========================================
    // state register, constants only under reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '{sync: 2'b00, level: 1'b0, deb_cnt: 32'h0000_0000, min_cnt: 48'h0000_0000_0000,
                   min_left: MINUTES_DEFAULT, tally_run: STAGE_ZERO, tally_last: STAGE_ZERO,
                   stage: TOTAL_ZERO, report: 1'b0, warning: 1'b0, hit: 1'b0};
        end else begin
            q <= d;
        end
    end

    // outputs straight from state flops
    assign low_stage = q.stage[0];
    assign second_stage = q.stage[1];
    assign third_byte_stage = q.stage[2];
    assign top_byte_stage = q.stage[3];
    assign last_count = q.tally_last;
    assign report_pulse = q.report;
    assign warning_out = q.warning;
    assign reset_hit = q.hit;

    // ==========================================
    // checks
    // they sit next to the counter they guard; all share clk and nrst
    // a plain clear leaves every stage at zero
    property p_clear_zero;
        @(posedge clk) disable iff (!nrst)
        clear_req && !edge_seen |=> {top_byte_stage, third_byte_stage, second_stage, low_stage} == TOTAL_ZERO;
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("clear did not zero stages");
    // a pulse accepted together with the clear is the first count after it
    property p_clear_pulse;
        @(posedge clk) disable iff (!nrst)
        clear_req && edge_seen |=> low_stage == 8'h00_01 && second_stage == STAGE_ZERO;
    endproperty
    a_clear_pulse: assert property (p_clear_pulse) else $error("coincident pulse lost on clear");
    // a low stage wrap must bump the second stage exactly once
    property p_carry;
        @(posedge clk) disable iff (!nrst)
        edge_seen && !cleared && low_stage == STAGE_MAX |=> low_stage == STAGE_ZERO
            && second_stage == $past(second_stage) + 8'd1;
    endproperty
    a_carry: assert property (p_carry) else $error("low stage carry wrong");
    // every accepted pulse without a clear or reset hit adds one to the low stage
    property p_count;
        @(posedge clk) disable iff (!nrst)
        edge_seen && !cleared |=> low_stage == $past(low_stage) + 8'd1;
    endproperty
    a_count: assert property (p_count) else $error("pulse not counted");
    // without pulse or clear the total must not drift
    property p_hold;
        @(posedge clk) disable iff (!nrst)
        !edge_seen && !clear_req |=> $stable({top_byte_stage, third_byte_stage, second_stage, low_stage});
    endproperty
    a_hold: assert property (p_hold) else $error("count moved without pulse");
    // warning follows the registered total against the threshold of the cycle before
    property p_warn;
        @(posedge clk) disable iff (!nrst)
        ##1 warning_out == ({top_byte_stage, third_byte_stage, second_stage, low_stage} >= $past(trigger_value));
    endproperty
    a_warn: assert property (p_warn) else $error("warning level wrong");
    // auto clear keeps only the excess, so the total falls below the limit
    property p_hit_clear;
        @(posedge clk) disable iff (!nrst)
        reset_hit |-> {top_byte_stage, third_byte_stage, second_stage, low_stage} < $past(reset_value);
    endproperty
    a_hit_clear: assert property (p_hit_clear) else $error("counter not cleared at hit");
    // the hit strobe lasts one cycle, as accepted edges never come back to back
    property p_hit_once;
        @(posedge clk) disable iff (!nrst)
        reset_hit |=> !reset_hit;
    endproperty
    a_hit_once: assert property (p_hit_once) else $error("hit strobe longer than one cycle");
    // an empty interval leaves the published tally alone
    property p_tally_keep;
        @(posedge clk) disable iff (!nrst)
        interval_end && q.tally_run == STAGE_ZERO && !edge_seen |=> $stable(last_count);
    endproperty
    a_tally_keep: assert property (p_tally_keep) else $error("tally cleared on empty interval");
    // a non-empty interval publishes its own count
    property p_tally_take;
        @(posedge clk) disable iff (!nrst)
        interval_end && q.tally_run != STAGE_ZERO && !edge_seen |=> last_count == $past(q.tally_run);
    endproperty
    a_tally_take: assert property (p_tally_take) else $error("interval tally not published");
    // the running tally sticks at its ceiling until the interval closes
    property p_tally_sat;
        @(posedge clk) disable iff (!nrst)
        q.tally_run == STAGE_MAX && !interval_end |=> q.tally_run == STAGE_MAX;
    endproperty
    a_tally_sat: assert property (p_tally_sat) else $error("running tally wrapped");
    // the full tally reports at once, without waiting for the interval end
    property p_tally_full;
        @(posedge clk) disable iff (!nrst)
        edge_seen && !interval_end && q.tally_run == STAGE_MAX - 8'd1 |=> report_pulse && last_count == STAGE_MAX;
    endproperty
    a_tally_full: assert property (p_tally_full) else $error("no report at full tally");
    // every interval end is reported
    property p_report;
        @(posedge clk) disable iff (!nrst)
        interval_end |=> report_pulse;
    endproperty
    a_report: assert property (p_report) else $error("no interval report");
    // one contact closure gives one accepted edge, never two in a row
    property p_edge_once;
        @(posedge clk) disable iff (!nrst)
        edge_seen |=> !edge_seen;
    endproperty
    a_edge_once: assert property (p_edge_once) else $error("closure accepted twice");
endmodule : cascaded_pulse_counter

// ### hw/pulse_counter_pkg.sv
// package for the cascaded pulse counter: widths, timing constants, state carriers
// assumes a single 100 MHz clock shared by every user of the package
package pulse_counter_pkg;
    // ==========================================
    // widths and stage limits
    localparam int STAGE_W = 8; // one byte per counter stage
    localparam int NUM_STAGES = 4; // low, second, third, top
    localparam int TOTAL_W = STAGE_W * NUM_STAGES; // 32-bit total
    localparam logic [7:0] STAGE_MAX = 8'h00_FF; // largest value a stage holds
    localparam logic [7:0] STAGE_ZERO = 8'h00_00; // cleared stage
    localparam logic [31:0] TOTAL_ZERO = 32'h0000_0000; // cleared total
    localparam logic [7:0] MINUTES_DEFAULT = 8'h00_01; // one-minute interval
    // ==========================================
    // timing
    localparam int CLK_HZ = 100_000_000; // system clock rate
    localparam int CLK_NS = 1_000_000_000 / CLK_HZ; // 10 ns period
    localparam int MIN_PULSE_MS = 250; // fastest accepted pulse period
    localparam int DEBOUNCE_MS = 10; // contact must hold this long
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (1_000_000 / CLK_NS); // rounds down, longest time
    localparam int MINUTE_S = 60; // one interval unit
    localparam longint MINUTE_CYC = longint'(MINUTE_S) * longint'(CLK_HZ); // cycles per minute
    // ==========================================
    // state carrier: whole register state of the counter
    typedef struct packed {
        logic [1:0] sync; // two-stage synchroniser
        logic level; // debounced contact level
        logic [31:0] deb_cnt; // debounce timer
        logic [47:0] min_cnt; // minute prescaler
        logic [7:0] min_left; // minutes left in interval
        logic [7:0] tally_run; // pulses in running interval
        logic [7:0] tally_last; // pulses of last interval
        logic [NUM_STAGES-1:0][STAGE_W-1:0] stage; // cascaded stages
        logic report; // report pulse to controller
        logic warning; // total reached trigger
        logic hit; // reset-condition output
    } count_state_s;
endpackage : pulse_counter_pkg

// ### sim/meter_source.sv
// meter contact model: one clean pulse per request
// assumes fire is a one-cycle strobe driven at the rising edge
`timescale 1ns/1ps
module meter_source #(
    parameter int HOLD = 10 // cycles high, then low, both above debounce
) (
    input wire logic clk, // bench clock
    input wire logic fire, // start one pulse
    output logic pulse_in, // contact level, high = closed
    output logic busy // pulse still in progress
);
    // ==========================================
    // pulse shaper
    int cnt = 0; // cycles into current pulse
    initial begin
        pulse_in = 1'b0;
        busy = 1'b0;
    end
    // high then low, so the next rise sees a settled low contact
    always @(posedge clk) begin
        if (fire && !busy) begin
            busy <= 1'b1;
            pulse_in <= 1'b1;
            cnt <= 0;
        end else if (busy) begin
            cnt <= cnt + 1;
            if (cnt == HOLD - 1) pulse_in <= 1'b0;
            if (cnt == 2 * HOLD - 1) busy <= 1'b0;
        end
    end
endmodule : meter_source

// ### sim/cascaded_pulse_counter_bench.sv
// bench for the cascaded pulse counter: intervals, carry, clears, thresholds
// assumes shortened debounce and minute counts handed to the instance
`timescale 1ns/1ps
module cascaded_pulse_counter_bench;
    import pulse_counter_pkg::*;
    // ==========================================
    // stimulus and observed signals
    logic clk = 1'b0; // 100 MHz
    logic nrst = 1'b0; // held low at start
    logic fire = 1'b0; // one pulse request
    logic busy, pulse_in; // contact source
    logic clear_req = 1'b0; // logic reset condition
    logic [7:0] interval_min = 8'h01; // one minute
    logic [31:0] trigger_value = 32'hFFFF_FFFF; // warning out of reach
    logic [31:0] reset_value = 32'h0000_0000; // auto clear off
    logic [7:0] low_stage, second_stage, third_byte_stage, top_byte_stage, last_count;
    logic report_pulse, warning_out, reset_hit;
    logic [31:0] total; // stages joined
    int error_cnt = 0, check_count = 0, rep_cnt = 0, hit_cnt = 0, r, h;
    assign total = {top_byte_stage, third_byte_stage, second_stage, low_stage};
    always #5 clk = ~clk;
    // one-cycle strobes are tallied so tasks never miss them
    always @(posedge clk) begin
        if (report_pulse === 1'b1) rep_cnt++;
        if (reset_hit === 1'b1) hit_cnt++;
    end
    // ==========================================
    // design and contact source
    cascaded_pulse_counter #(.DEBOUNCE_CYCLES(4), .MINUTE_CYCLES(100)) DUT (.clk(clk), .nrst(nrst),
        .pulse_in(pulse_in), .clear_req(clear_req), .interval_min(interval_min), .trigger_value(trigger_value),
        .reset_value(reset_value), .low_stage(low_stage), .second_stage(second_stage),
        .third_byte_stage(third_byte_stage), .top_byte_stage(top_byte_stage), .last_count(last_count),
        .report_pulse(report_pulse), .warning_out(warning_out), .reset_hit(reset_hit));
    meter_source src (.clk(clk), .fire(fire), .pulse_in(pulse_in), .busy(busy));
    // ==========================================
    // shared tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // whole pulses only; source busy covers high and low time
    task automatic send(input int n);
        repeat (n) begin
            @(posedge clk) fire <= 1'b1;
            @(posedge clk) fire <= 1'b0;
            #1;
            while (busy) @(posedge clk) #1;
        end
    endtask : send
    // bounded wait, longer than the longest interval
    task automatic wait_report();
        r = rep_cnt;
        repeat (30000) if (rep_cnt == r) @(posedge clk) #1;
        check("report seen", 32'(rep_cnt != r), 32'h0000_0001);
    endtask : wait_report
    task automatic clear_all();
        @(posedge clk) clear_req <= 1'b1;
        @(posedge clk) clear_req <= 1'b0;
        @(posedge clk) #1;
        check("cleared total", total, 32'h0000_0000);
    endtask : clear_all
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    // ==========================================
    // scenarios
    task automatic t_interval();
        wait_report();
        send(3);
        wait_report();
        check("last_count", last_count, 32'h0000_0003);
        wait_report();
        check("kept tally", last_count, 32'h0000_0003);
        $display("done interval tally");
    endtask : t_interval
    // long interval so only the full tally can report
    task automatic t_carry();
        clear_all();
        @(posedge clk) interval_min <= 8'hFF;
        wait_report();
        h = rep_cnt;
        send(255);
        check("full tally", last_count, 32'h0000_00FF);
        check("tally report", 32'(rep_cnt - h), 32'h0000_0001);
        send(1);
        check("low_stage", low_stage, 32'h0000_0000);
        check("second_stage", second_stage, 32'h0000_0001);
        check("total", total, 32'h0000_0100);
        $display("done carry");
    endtask : t_carry
    // clear lands in the very cycle the pulse is accepted: that pulse must survive
    // contact rises at the edge fire is seen; sync and debounce accept it seven edges after fire rises
    task automatic t_coincide();
        @(posedge clk) fire <= 1'b1;
        @(posedge clk) fire <= 1'b0;
        repeat (4) @(posedge clk);
        @(posedge clk) clear_req <= 1'b1;
        @(posedge clk) clear_req <= 1'b0;
        #1;
        while (busy) @(posedge clk) #1;
        check("clear with pulse", total, 32'h0000_0001);
        $display("done coincident clear");
    endtask : t_coincide
    task automatic t_thresh();
        clear_all();
        @(posedge clk) trigger_value <= 32'h0000_0002;
        reset_value <= 32'h0000_0003;
        send(2);
        check("warning", 32'(warning_out), 32'h0000_0001);
        h = hit_cnt;
        send(1);
        check("reset_hit", 32'(hit_cnt - h), 32'h0000_0001);
        check("auto cleared", total, 32'h0000_0000);
        send(1);
        check("next pulse kept", total, 32'h0000_0001);
        $display("done thresholds");
    endtask : t_thresh
    // ==========================================
    // main sequence and watchdog
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_interval();
        t_carry();
        t_coincide();
        t_thresh();
        end_of_test();
    end
    initial begin
        #600_000;
        error_cnt++;
        end_of_test();
    end
endmodule : cascaded_pulse_counter_bench
